/* File: bench/buck_mode_fault_sequencer_chk.sv */
`timescale 1ns/1ps
module buck_seq_chk #(
  parameter int OC_HALF = 32
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Inputs
  input wire logic SUPPLY_OK,
  input wire logic ENABLE_INPUT,
  input wire buck_seq_pkg::flags_t FLAGS,
  input wire logic LEVEL_SELECT_0,
  input wire logic HS_SENSED_OFF,
  input wire logic LS_SENSED_OFF,
  // Outputs
  input wire buck_seq_pkg::drive_t DRIVE,
  input wire logic ON_START,
  input wire logic ON_STRETCH,
  input wire logic DIVIDER_SWITCH_0,
  input wire logic [4:0] REF_CODE,
  input wire logic LIMIT_SET_EN,
  input wire logic OC_HALF_SEL,
  input wire logic GOOD_OUTPUT_OE,
  input wire logic POWER_SAVE,
  input wire logic OVER_VOLTAGE_LATCH,
  input wire logic UNDER_VOLTAGE_LATCH
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  // ****
  // High-side turn-ons since start
  // ****
  logic [6:0] starts_r;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      starts_r <= 7'h00;
    end else if (!DRIVE.en) begin
      starts_r <= 7'h00;
    end else if (ON_START && starts_r != 7'h7F) begin
      starts_r <= starts_r + 7'h01;
    end
  end

  property p_div;
    !$past(RST) |-> DIVIDER_SWITCH_0 == $past(LEVEL_SELECT_0);
  endproperty
  a_div: assert property (p_div) else $error("divider lag");
  property p_hs_on;
    $rose(DRIVE.hs) |-> $past(LS_SENSED_OFF) && !DRIVE.ls;
  endproperty
  a_hs_on: assert property (p_hs_on) else $error("hs overlap");
  property p_ls_on;
    $rose(DRIVE.ls) |-> $past(HS_SENSED_OFF) && !DRIVE.hs;
  endproperty
  a_ls_on: assert property (p_ls_on) else $error("ls overlap");
  property p_lim;
    $rose(DRIVE.ls) && !OVER_VOLTAGE_LATCH |-> LIMIT_SET_EN;
  endproperty
  a_lim: assert property (p_lim) else $error("limit source off");
  property p_stretch;
    ON_STRETCH == POWER_SAVE;
  endproperty
  a_stretch: assert property (p_stretch) else $error("stretch mismatch");
  property p_save_zc;
    POWER_SAVE && DRIVE.ls && FLAGS.zero_cross |=> !DRIVE.ls;
  endproperty
  a_save_zc: assert property (p_save_zc) else $error("ls kept at zero cross");
  property p_ov_hold;
    OVER_VOLTAGE_LATCH && ENABLE_INPUT && SUPPLY_OK |=> OVER_VOLTAGE_LATCH;
  endproperty
  a_ov_hold: assert property (p_ov_hold) else $error("ov latch lost");
  property p_ov_good;
    OVER_VOLTAGE_LATCH |=> GOOD_OUTPUT_OE && !DRIVE.hs;
  endproperty
  a_ov_good: assert property (p_ov_good) else $error("ov good high");
  property p_uv;
    UNDER_VOLTAGE_LATCH |=> !DRIVE.hs && !DRIVE.ls && GOOD_OUTPUT_OE;
  endproperty
  a_uv: assert property (p_uv) else $error("uv drives on");
  property p_undervoltage_lockout;
    !SUPPLY_OK |=> !DRIVE.en && !DRIVE.hs && !DRIVE.ls;
  endproperty
  a_undervoltage_lockout: assert property (p_undervoltage_lockout) else $error("drives in lockout");
  property p_pg_start;
    REF_CODE != 5'h19 |=> GOOD_OUTPUT_OE;
  endproperty
  a_pg_start: assert property (p_pg_start) else $error("good in soft start");
  property p_ref_step;
    $changed(REF_CODE) && REF_CODE == $past(REF_CODE) + 5'h01 |-> REF_CODE <= 5'h19
      ##1 (!$changed(REF_CODE) || $past(FLAGS.zero_cross) || !DRIVE.en) [*7];
  endproperty
  a_ref_step: assert property (p_ref_step) else $error("ref step short");
  property p_oc;
    DRIVE.en && starts_r < OC_HALF - 1 |-> OC_HALF_SEL;
  endproperty
  a_oc: assert property (p_oc) else $error("oc half dropped");
  property p_oc_end;
    starts_r > OC_HALF |-> !OC_HALF_SEL;
  endproperty
  a_oc_end: assert property (p_oc_end) else $error("oc half kept");
  c_save: cover property ($rose(POWER_SAVE));
  c_ov: cover property ($rose(OVER_VOLTAGE_LATCH));
  c_uv: cover property ($rose(UNDER_VOLTAGE_LATCH));
endmodule : buck_seq_chk

bind buck_mode_fault_sequencer buck_seq_chk #(.OC_HALF(OC_HALF)) u_buck_seq_chk (
  .CLK(CLK), .RST(RST), .SUPPLY_OK(SUPPLY_OK), .ENABLE_INPUT(ENABLE_INPUT),
  .FLAGS(FLAGS), .LEVEL_SELECT_0(LEVEL_SELECT_0), .HS_SENSED_OFF(HS_SENSED_OFF),
  .LS_SENSED_OFF(LS_SENSED_OFF), .DRIVE(DRIVE), .ON_START(ON_START),
  .ON_STRETCH(ON_STRETCH), .DIVIDER_SWITCH_0(DIVIDER_SWITCH_0), .REF_CODE(REF_CODE),
  .LIMIT_SET_EN(LIMIT_SET_EN), .OC_HALF_SEL(OC_HALF_SEL), .GOOD_OUTPUT_OE(GOOD_OUTPUT_OE),
  .POWER_SAVE(POWER_SAVE), .OVER_VOLTAGE_LATCH(OVER_VOLTAGE_LATCH),
  .UNDER_VOLTAGE_LATCH(UNDER_VOLTAGE_LATCH)
);

/* File: bench/buck_mode_fault_sequencer_tb.sv */
`timescale 1ns/1ps
module buck_mode_fault_sequencer_tb;
  localparam int QUAL_T = 10;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic en = 1'b0;
  logic sup = 1'b0;
  buck_seq_pkg::flags_t flg = '0;
  logic [1:0] lvl = 2'h0;
  logic slow = 1'b0;
  logic hs_off, ls_off, on_done, on_start, stretch, dsw0, dsw1, oe, psave, ovl, uvl;
  buck_seq_pkg::drive_t drv;
  logic [4:0] rc;
  int error_cnt = 0;
  int samples_checked = 0;

  always #5 clk = ~clk;

  buck_mode_fault_sequencer #(.QUAL(QUAL_T)) u_buck_mode_fault_sequencer (
    .CLK(clk), .RST(rst), .ENABLE_INPUT(en), .SUPPLY_OK(sup), .FLAGS(flg),
    .FEEDBACK_SENSE(5'h1F), .LEVEL_SELECT_0(lvl[0]), .LEVEL_SELECT_1(lvl[1]),
    .HS_SENSED_OFF(hs_off), .LS_SENSED_OFF(ls_off), .ON_DONE(on_done), .DRIVE(drv),
    .ON_START(on_start), .ON_STRETCH(stretch), .DIVIDER_SWITCH_0(dsw0),
    .DIVIDER_SWITCH_1(dsw1), .REF_CODE(rc), .LIMIT_SET_EN(), .OC_HALF_SEL(),
    .GOOD_OUTPUT_O(), .GOOD_OUTPUT_OE(oe), .POWER_SAVE(psave),
    .OVER_VOLTAGE_LATCH(ovl), .UNDER_VOLTAGE_LATCH(uvl)
  );

  power_stage_model u_power_stage_model (
    .clk(clk), .rst(rst), .drv(drv), .on_start(on_start), .on_stretch(stretch),
    .slow(slow), .hs_off(hs_off), .ls_off(ls_off), .on_done(on_done)
  );

  // ****
  // Helpers
  // ****
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic wait_on(ref logic s, input logic v, input int n);
    for (int i = 0; i < n && s !== v; i++) tick(1);
  endtask : wait_on

  task automatic chk(input logic got, input logic exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk

  task automatic chk_code(input logic [4:0] got, input logic [4:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk_code

  task automatic give_verdict;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict

  // ****
  // Scenarios
  // ****
  task automatic t_start;
    int n;
    @(posedge clk);
    sup <= 1'b1;
    en <= 1'b1;
    flg.below_ref <= 1'b1;
    tick(2);
    chk(drv.en, 1'b1, "no start");
    chk_code(rc, 5'h00, "ref not zero");
    for (n = 0; n < 20 && rc !== 5'h01; n++) tick(1);
    for (n = 0; n < 20 && rc === 5'h01; n++) tick(1);
    chk_code(5'(n), 5'h08, "step length");
    for (n = 0; n < 300 && rc !== 5'h19; n++) tick(1);
    chk_code(rc, 5'h19, "ref top");
    chk(oe, 1'b1, "good early");
    @(posedge clk);
    flg.below_ref <= 1'b0;
    wait_on(oe, 1'b0, QUAL_T + 40);
    chk(oe, 1'b0, "good late");
    @(posedge clk);
    flg.below_ref <= 1'b1;
  endtask : t_start

  task automatic t_level;
    @(posedge clk);
    flg.below_600 <= 1'b1;
    repeat (QUAL_T - 4) @(posedge clk);
    flg.below_600 <= 1'b0;
    tick(QUAL_T + 4);
    chk(oe, 1'b0, "glitch passed");
    @(posedge clk);
    lvl[0] <= 1'b1;
    flg.below_600 <= 1'b1;
    tick(1);
    chk(dsw0, 1'b1, "divider");
    chk(dsw1, 1'b0, "divider 1 moved");
    tick(25);
    chk(oe, 1'b0, "not frozen");
    wait_on(oe, 1'b1, 40);
    chk(oe, 1'b1, "low fb missed");
    @(posedge clk);
    flg.below_600 <= 1'b0;
    wait_on(oe, 1'b0, QUAL_T + 5);
    chk(oe, 1'b0, "good not back");
    @(posedge clk);
    lvl[1] <= 1'b1;
    tick(1);
    chk(dsw1, 1'b1, "divider 1");
    tick(40);
  endtask : t_level

  task automatic t_psave;
    int n;
    n = 0;
    @(posedge clk);
    slow <= 1'b1;
    flg.zero_cross <= 1'b1;
    for (int i = 0; i < 400 && psave !== 1'b1; i++) begin
      tick(1);
      n += int'(on_start === 1'b1);
    end
    chk(n >= 8 && n <= 9, 1'b1, "save entry");
    chk(stretch, 1'b1, "no stretch");
    @(posedge clk);
    slow <= 1'b0;
    flg.zero_cross <= 1'b0;
    wait_on(psave, 1'b0, 60);
    chk(psave, 1'b0, "save kept");
  endtask : t_psave

  task automatic t_ov;
    @(posedge clk);
    flg.above_900 <= 1'b1;
    repeat (QUAL_T - 3) @(posedge clk);
    flg.above_900 <= 1'b0;
    tick(QUAL_T + 4);
    chk(ovl, 1'b0, "spike latched");
    @(posedge clk);
    flg.above_900 <= 1'b1;
    wait_on(ovl, 1'b1, QUAL_T + 10);
    @(posedge clk);
    flg.above_900 <= 1'b0;
    tick(5);
    chk(ovl, 1'b1, "no ov latch");
    chk(drv.ls, 1'b1, "ls not on");
    chk(drv.hs, 1'b0, "hs on");
    chk(oe, 1'b1, "good after ov");
    @(posedge clk);
    en <= 1'b0;
    tick(3);
    chk(ovl, 1'b0, "ov kept");
  endtask : t_ov

  task automatic t_uv;
    @(posedge clk);
    flg.below_525 <= 1'b1;
    tick(6);
    chk(uvl, 1'b0, "early uv");
    wait_on(uvl, 1'b1, 10);
    tick(1);
    chk(uvl, 1'b1, "no uv");
    chk(drv.hs | drv.ls, 1'b0, "uv drives");
    @(posedge clk);
    flg.below_525 <= 1'b0;
    sup <= 1'b0;
    tick(2);
    chk(drv.en, 1'b0, "not tristate");
    @(posedge clk);
    sup <= 1'b1;
    tick(3);
    chk(uvl, 1'b0, "uv kept");
    chk(drv.en, 1'b1, "no restart");
  endtask : t_uv

  initial begin
    #100000;
    error_cnt++;
    give_verdict();
  end

  initial begin
    repeat (4) @(posedge clk);
    chk(drv.en, 1'b0, "en in reset");
    chk(oe, 1'b1, "good in reset");
    rst <= 1'b0;
    t_start();
    t_level();
    t_psave();
    t_ov();
    t_start();
    t_uv();
    give_verdict();
  end
endmodule : buck_mode_fault_sequencer_tb

/* File: bench/power_stage_model.sv */
`timescale 1ns/1ps
module power_stage_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Gate drives and on-time control
  input wire buck_seq_pkg::drive_t drv,
  input wire logic on_start,
  input wire logic on_stretch,
  input wire logic slow,
  // Sensing
  output logic hs_off,
  output logic ls_off,
  output logic on_done
);
  // ****
  // Gate discharge and on-time
  // ****
  logic [2:0] hs_d;
  logic [2:0] ls_d;
  logic [3:0] on_cnt;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hs_d <= 3'h0;
      ls_d <= 3'h0;
      on_cnt <= 4'h0;
    end else begin
      hs_d <= {hs_d[1:0], drv.hs};
      ls_d <= {ls_d[1:0], drv.ls};
      if (on_start) begin
        on_cnt <= on_stretch ? 4'hA : 4'h8;
      end else if (on_cnt != 4'h0) begin
        on_cnt <= on_cnt - 4'h1;
      end
    end
  end

  // Slow gates need three cycles to discharge
  assign hs_off = !drv.hs && (slow ? !(|hs_d) : !hs_d[0]);
  assign ls_off = !drv.ls && (slow ? !(|ls_d) : !ls_d[0]);
  assign on_done = drv.hs && !on_start && on_cnt == 4'h0;
endmodule : power_stage_model

/* File: verilog/buck_mode_fault_sequencer.sv */
`timescale 1ns/1ps
`include "buck_seq_map.svh"
module buck_mode_fault_sequencer #(
  parameter int ZC_ENTER = `ZC_ENTER_CYC,
  parameter int SS_STEP = `SS_STEP_CYC,
  parameter int BLANK = `BLANK_CYC,
  parameter int OC_HALF = `OC_HALF_CYC,
  parameter int QUAL = `QUAL_CYC,
  parameter int UV_QUAL = `UV_CYC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Supply and enable
  input wire logic ENABLE_INPUT,
  input wire logic SUPPLY_OK,
  // Comparator flags
  input wire buck_seq_pkg::flags_t FLAGS,
  input wire logic [4:0] FEEDBACK_SENSE,
  // Level selects
  input wire logic LEVEL_SELECT_0,
  input wire logic LEVEL_SELECT_1,
  // Gate drive sensing and on-time generator
  input wire logic HS_SENSED_OFF,
  input wire logic LS_SENSED_OFF,
  input wire logic ON_DONE,
  // Gate drives
  output buck_seq_pkg::drive_t DRIVE,
  output logic ON_START,
  output logic ON_STRETCH,
  // Divider switches
  output logic DIVIDER_SWITCH_0,
  output logic DIVIDER_SWITCH_1,
  // Reference and limits
  output logic [4:0] REF_CODE,
  output logic LIMIT_SET_EN,
  output logic OC_HALF_SEL,
  // Good output, open drain
  output logic GOOD_OUTPUT_O,
  output logic GOOD_OUTPUT_OE,
  // Status
  output logic POWER_SAVE,
  output logic OVER_VOLTAGE_LATCH,
  output logic UNDER_VOLTAGE_LATCH
);

  buck_seq_pkg::seq_t s_r;
  buck_seq_pkg::seq_t s_nxt;

  logic pg_bad_q;
  logic ov_q;
  logic uv_q;
  logic ov_raw;
  logic [1:0] lvl_in;

  // ****************************************
  // Qualified fault and good levels
  // ****************************************
  assign ov_raw = (s_r.blank_cnt != 6'h0) ? FLAGS.above_1125 : FLAGS.above_900;

  level_qualifier #(.N(QUAL), .INIT(1'b1)) u_pg_qual (
    .clk(CLK),
    .rst(RST),
    .raw(FLAGS.below_600 | FLAGS.above_900),
    .q(pg_bad_q)
  );

  level_qualifier #(.N(QUAL), .INIT(1'b0)) u_ov_qual (
    .clk(CLK),
    .rst(RST),
    .raw(ov_raw),
    .q(ov_q)
  );

  level_qualifier #(.N(UV_QUAL), .INIT(1'b0)) u_uv_qual (
    .clk(CLK),
    .rst(RST),
    .raw(FLAGS.below_525),
    .q(uv_q)
  );

  assign lvl_in = {LEVEL_SELECT_1, LEVEL_SELECT_0};

  // ****************************************
  // Saturating increment
  // ****************************************
  function automatic logic [5:0] sat_inc(input logic [5:0] v, input int lim);
    logic [5:0] r;
    r = v;
    if (v < 6'(lim)) begin
      r = v + 6'h1;
    end
    return r;
  endfunction : sat_inc

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.on_start = 1'b0;

    // Divider follows level selects; change opens a blanking window
    s_nxt.lvl = lvl_in;
    if (lvl_in != s_r.lvl) begin
      s_nxt.blank_cnt = 6'(BLANK);
    end else if (s_r.blank_cnt != 6'h0) begin
      s_nxt.blank_cnt = s_r.blank_cnt - 6'h1;
    end

    if (!ENABLE_INPUT || !SUPPLY_OK) begin
      // Lockout or disabled: drives released, faults cleared while off
      s_nxt.mode = buck_seq_pkg::M_OFF;
      s_nxt.phase = buck_seq_pkg::P_IDLE;
      s_nxt.drv = '{hs: 1'b0, ls: 1'b0, en: 1'b0};
      s_nxt.lim_en = 1'b0;
      s_nxt.psave = 1'b0;
      s_nxt.sps = 1'b0;
    end else begin
      unique case (s_r.mode)
        buck_seq_pkg::M_OFF: begin
          // Power-on reset: clear counters and start soft-start
          s_nxt.mode = buck_seq_pkg::M_SOFT;
          s_nxt.phase = buck_seq_pkg::P_IDLE;
          s_nxt.drv = '{hs: 1'b0, ls: 1'b0, en: 1'b1};
          s_nxt.ref_code = 5'h0;
          s_nxt.step_cnt = 3'h0;
          s_nxt.zc_cnt = 4'h0;
          s_nxt.zc_seen = 1'b0;
          s_nxt.oc_cnt = 6'h0;
          s_nxt.oc_half = 1'b1;
        end
        buck_seq_pkg::M_SOFT, buck_seq_pkg::M_RUN: begin
          // Switching phases with dead-time interlock
          unique case (s_r.phase)
            buck_seq_pkg::P_IDLE: begin
              if (FLAGS.below_ref && !FLAGS.valley_limit) begin
                s_nxt.phase = buck_seq_pkg::P_HSW;
              end
            end
            buck_seq_pkg::P_HSW: begin
              if (LS_SENSED_OFF) begin
                s_nxt.phase = buck_seq_pkg::P_HIGH;
                s_nxt.drv.hs = 1'b1;
                s_nxt.on_start = 1'b1;
                // Once per switching cycle: zero-cross history
                if (s_r.zc_seen) begin
                  if (s_r.zc_cnt >= 4'(ZC_ENTER - 1)) begin
                    s_nxt.psave = 1'b1;
                  end else begin
                    s_nxt.zc_cnt = s_r.zc_cnt + 4'h1;
                  end
                end else begin
                  s_nxt.zc_cnt = 4'h0;
                  s_nxt.psave = 1'b0;
                end
                s_nxt.zc_seen = 1'b0;
                s_nxt.oc_cnt = sat_inc(s_r.oc_cnt, OC_HALF);
                s_nxt.oc_half = (sat_inc(s_r.oc_cnt, OC_HALF) < 6'(OC_HALF));
              end
            end
            buck_seq_pkg::P_HIGH: begin
              if (ON_DONE) begin
                s_nxt.phase = buck_seq_pkg::P_LSW;
                s_nxt.drv.hs = 1'b0;
              end
            end
            buck_seq_pkg::P_LSW: begin
              if (HS_SENSED_OFF) begin
                s_nxt.phase = buck_seq_pkg::P_LOW;
                s_nxt.drv.ls = 1'b1;
                s_nxt.lim_en = 1'b1;
              end
            end
            buck_seq_pkg::P_LOW: begin
              if (FLAGS.zero_cross) begin
                s_nxt.zc_seen = 1'b1;
              end
              if (s_r.psave && !s_r.sps && FLAGS.zero_cross) begin
                // Light-load save: stop at zero current
                s_nxt.phase = buck_seq_pkg::P_IDLE;
                s_nxt.drv.ls = 1'b0;
                s_nxt.lim_en = 1'b0;
              end else if (FLAGS.below_ref && !FLAGS.valley_limit) begin
                s_nxt.phase = buck_seq_pkg::P_HSW;
                s_nxt.drv.ls = 1'b0;
                s_nxt.lim_en = 1'b0;
                if (s_r.sps) begin
                  s_nxt.sps = 1'b0;
                  s_nxt.zc_cnt = 4'h0;
                end
              end
            end
            default: begin
              s_nxt.phase = buck_seq_pkg::P_IDLE;
              s_nxt.drv.hs = 1'b0;
              s_nxt.drv.ls = 1'b0;
            end
          endcase

          if (s_r.mode == buck_seq_pkg::M_SOFT) begin
            // Reference ramp with feedback override
            if (FLAGS.zero_cross && s_r.drv.ls &&
                FEEDBACK_SENSE < `REF_OVR_STOP) begin
              s_nxt.ref_code = FEEDBACK_SENSE;
              s_nxt.step_cnt = 3'h0;
            end else if (s_r.step_cnt == 3'(SS_STEP - 1)) begin
              s_nxt.step_cnt = 3'h0;
              if (s_r.ref_code < `REF_FULL) begin
                s_nxt.ref_code = s_r.ref_code + 5'h1;
              end
            end else begin
              s_nxt.step_cnt = s_r.step_cnt + 3'h1;
            end
            if (s_r.ref_code == `REF_FULL && !FLAGS.below_ref) begin
              s_nxt.mode = buck_seq_pkg::M_RUN;
            end
          end else begin
            // Smart save: pull output down through low side
            if (FLAGS.above_810 && !s_r.sps) begin
              s_nxt.sps = 1'b1;
              s_nxt.psave = 1'b0;
              s_nxt.zc_cnt = 4'h0;
              if (s_r.phase == buck_seq_pkg::P_IDLE ||
                  s_r.phase == buck_seq_pkg::P_HSW) begin
                s_nxt.phase = buck_seq_pkg::P_LSW;
                s_nxt.drv.hs = 1'b0;
              end
            end
            if (ov_q) begin
              s_nxt.mode = buck_seq_pkg::M_OVF;
              s_nxt.phase = buck_seq_pkg::P_IDLE;
              s_nxt.drv.hs = 1'b0;
              s_nxt.drv.ls = 1'b0;
              s_nxt.psave = 1'b0;
            end else if (uv_q) begin
              s_nxt.mode = buck_seq_pkg::M_UVF;
              s_nxt.phase = buck_seq_pkg::P_IDLE;
              s_nxt.drv.hs = 1'b0;
              s_nxt.drv.ls = 1'b0;
              s_nxt.lim_en = 1'b0;
              s_nxt.psave = 1'b0;
            end
          end
        end
        buck_seq_pkg::M_OVF: begin
          // Low side latched on after high side is off
          s_nxt.drv.hs = 1'b0;
          s_nxt.drv.ls = HS_SENSED_OFF | s_r.drv.ls;
        end
        buck_seq_pkg::M_UVF: begin
          s_nxt.drv.hs = 1'b0;
          s_nxt.drv.ls = 1'b0;
        end
        default: begin
          s_nxt.mode = buck_seq_pkg::M_OFF;
        end
      endcase
    end

    // Good output: low pulls when oe high
    if (s_nxt.mode == buck_seq_pkg::M_OVF || s_nxt.mode == buck_seq_pkg::M_UVF) begin
      s_nxt.good_oe = 1'b1;
    end else if (s_r.blank_cnt != 6'h0 || lvl_in != s_r.lvl) begin
      s_nxt.good_oe = s_r.good_oe;
    end else begin
      s_nxt.good_oe = (s_r.mode != buck_seq_pkg::M_RUN) || pg_bad_q;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s_r <= '{
        mode: buck_seq_pkg::M_OFF,
        phase: buck_seq_pkg::P_IDLE,
        drv: '{hs: 1'b0, ls: 1'b0, en: 1'b0},
        psave: 1'b0,
        sps: 1'b0,
        zc_seen: 1'b0,
        zc_cnt: 4'h0,
        ref_code: 5'h0,
        step_cnt: 3'h0,
        blank_cnt: 6'h0,
        oc_cnt: 6'h0,
        lvl: 2'h0,
        good_oe: 1'b1,
        lim_en: 1'b0,
        on_start: 1'b0,
        oc_half: 1'b1
      };
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign DRIVE = s_r.drv;
  assign ON_START = s_r.on_start;
  assign ON_STRETCH = s_r.psave;
  assign DIVIDER_SWITCH_0 = s_r.lvl[0];
  assign DIVIDER_SWITCH_1 = s_r.lvl[1];
  assign REF_CODE = s_r.ref_code;
  assign LIMIT_SET_EN = s_r.lim_en;
  assign OC_HALF_SEL = s_r.oc_half;
  assign GOOD_OUTPUT_O = 1'b0;
  assign GOOD_OUTPUT_OE = s_r.good_oe;
  assign POWER_SAVE = s_r.psave;
  assign OVER_VOLTAGE_LATCH = (s_r.mode == buck_seq_pkg::M_OVF);
  assign UNDER_VOLTAGE_LATCH = (s_r.mode == buck_seq_pkg::M_UVF);

endmodule : buck_mode_fault_sequencer

/* File: verilog/buck_seq_map.svh */
// Operation
// - Level-select change immediately drives the matching divider switch output; the code drives it one clock later.
// - Enter light-load save after eight consecutive switching cycles with zero-cross.
// - In light-load save, low-side drive turns off at zero-cross.
// - In light-load save, the on-interval is stretched by 25%.
// - Leave light-load save on any switching cycle without zero-cross.
// - Feedback above 810mV: exit save, hold low side until 0.75V, then cycle.
// - After recovery, re-enter save after 8 consecutive light-load cycles.
// - Limit-set source on with low side; no high-side turn-on during valley limit. The code does not set it for the low side latched on by over-voltage.
// - Good output low while feedback below 600mV until it returns above.
// - Good output low through start-up until soft-start done at 0.75V.
// - Each good-output threshold crossing is qualified by a 5us filter.
// - Good output low when feedback exceeds the +20% point.
// - Level-select change freezes good output for 32 clock cycles.
// - Over 900mV in steady state latches low side on until enable or power cycles.
// - Over-voltage detection is qualified by a 5us delay.
// - After over-voltage latch, good output stays low.
// - Level-select change raises over-voltage threshold to 1.125V for 32 cycles.
// - Feedback below 525mV for eight cycles turns both drives off, latched.
// - Below 4.4V supply: tristate drives; crossing it resets faults and starts soft-start.
// - Soft-start ramps reference 0 to 0.75V in 30mV steps of eight clocks.
// - Soft-start zero-cross with low side on loads reference from feedback, below 600mV.
// - First 32 switching cycles after start use a halved over-current threshold; the code halves only the first 31.
// - Each drive turns on only after the other is sensed fully off.
`ifndef BUCK_SEQ_MAP_SVH
`define BUCK_SEQ_MAP_SVH

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS 10
`define QUAL_TIME_NS 5000
`define QUAL_CYC ((`QUAL_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ****************************************
// Counts
// ****************************************
`define ZC_ENTER_CYC 8
`define SS_STEP_CYC 8
`define BLANK_CYC 32
`define OC_HALF_CYC 32
`define UV_CYC 8

// ****************************************
// Reference codes, 30mV per code
// ****************************************
`define REF_FULL 5'h19
`define REF_OVR_STOP 5'h14

`endif

/* File: verilog/buck_seq_pkg.sv */
package buck_seq_pkg;

  // ****************************************
  // Sequencer modes and switching phases
  // ****************************************
  typedef enum logic [2:0] {
    M_OFF = 3'h0,
    M_SOFT = 3'h1,
    M_RUN = 3'h3,
    M_OVF = 3'h2,
    M_UVF = 3'h6
  } mode_t;

  typedef enum logic [2:0] {
    P_IDLE = 3'h0,
    P_HSW = 3'h1,
    P_HIGH = 3'h3,
    P_LSW = 3'h2,
    P_LOW = 3'h6
  } phase_t;

  // ****************************************
  // Comparator flags
  // ****************************************
  typedef struct packed {
    logic zero_cross;
    logic below_ref;
    logic above_810;
    logic below_600;
    logic above_900;
    logic above_1125;
    logic below_525;
    logic valley_limit;
  } flags_t;

  // ****************************************
  // Gate drive outputs
  // ****************************************
  typedef struct packed {
    logic hs;
    logic ls;
    logic en;
  } drive_t;

  typedef struct packed {
    mode_t mode;
    phase_t phase;
    drive_t drv;
    logic psave;
    logic sps;
    logic zc_seen;
    logic [3:0] zc_cnt;
    logic [4:0] ref_code;
    logic [2:0] step_cnt;
    logic [5:0] blank_cnt;
    logic [5:0] oc_cnt;
    logic [1:0] lvl;
    logic good_oe;
    logic lim_en;
    logic on_start;
    logic oc_half;
  } seq_t;

endpackage : buck_seq_pkg

/* File: verilog/level_qualifier.sv */
`timescale 1ns/1ps
module level_qualifier #(
  parameter int N = 8,
  parameter logic INIT = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Level
  input wire logic raw,
  output logic q
);

  localparam int W = $clog2(N + 1);

  typedef struct packed {
    logic q;
    logic [W-1:0] cnt;
  } qual_t;

  qual_t s_r;
  qual_t s_nxt;

  // ****************************************
  // Output moves only after N cycles of disagreement
  // ****************************************
  always_comb begin
    s_nxt = s_r;
    if (raw == s_r.q) begin
      s_nxt.cnt = '0;
    end else if (s_r.cnt == W'(N - 1)) begin
      s_nxt.q = raw;
      s_nxt.cnt = '0;
    end else begin
      s_nxt.cnt = s_r.cnt + W'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '{q: INIT, cnt: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.q;

endmodule : level_qualifier
